// ==== rtl/fskdb_pkg.sv ====
package fskdb_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] FSKDB_ADR_SETUP = 8'h00;
   localparam logic [7:0] FSKDB_ADR_CORR = 8'h04;
   localparam logic [7:0] FSKDB_ADR_SYNC_CFG = 8'h08;
   localparam logic [7:0] FSKDB_ADR_SYNC_WORD = 8'h0C;
   localparam logic [7:0] FSKDB_ADR_STATUS = 8'h10;
   localparam logic [7:0] FSKDB_ADR_MASK = 8'h14;
   localparam logic [7:0] FSKDB_ADR_LIVE = 8'h18;
   localparam logic [7:0] FSKDB_ADR_CDR_DIV = 8'h1C;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int FSKDB_SEL_LSB = 4;
   localparam int FSKDB_BW_LSB = 6;
   localparam int FSKDB_MODE_LSB = 23;
   localparam int FSKDB_CBW_LSB = 4;
   localparam int FSKDB_LEN_LSB = 4;
   localparam int FSKDB_TOL_LSB = 6;
   localparam int FSKDB_DW = 12;
   // ---------------------------------------------------------------
   // Codes and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] FSKDB_SEL_LINEAR = 2'h0;
   localparam logic [1:0] FSKDB_SEL_CORR = 2'h1;
   localparam logic [2:0] FSKDB_MODE_SYNC_A = 3'h2;
   localparam logic [2:0] FSKDB_MODE_SYNC_B = 3'h3;
   localparam logic [31:0] FSKDB_RST_SETUP = 32'h0000_0010;
   localparam logic [31:0] FSKDB_RST_CORR = 32'h0000_0000;
   localparam logic [7:0] FSKDB_RST_SYNC_CFG = 8'h00;
   localparam logic [23:0] FSKDB_RST_SYNC_WORD = 24'h00_0000;
   localparam logic [15:0] FSKDB_RST_CDR_DIV = 16'h0000;
   // ---------------------------------------------------------------
   // Timing counts
   // ---------------------------------------------------------------
   localparam logic [4:0] FSKDB_OVERSAMPLE_LAST = 5'h1F;
   localparam logic [4:0] FSKDB_PHASE_SAMPLE = 5'h10;
   localparam logic [3:0] FSKDB_MATCH_HOLD_BITS = 4'h9;
   localparam int FSKDB_AVG_SHIFT = 6;
endpackage

// ==== rtl/fskdb_lpf2.sv ====
`timescale 1ns/1ns
`default_nettype none
module fskdb_lpf2 (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic in_valid,
   input wire logic signed [fskdb_pkg::FSKDB_DW-1:0] x,
   input wire logic [9:0] k,
   output logic signed [fskdb_pkg::FSKDB_DW-1:0] y
);
   import fskdb_pkg::*;

   // Two cascaded first-order sections with 10 fractional bits each.
   // The coefficient is the bandwidth setting scaled by 2^-10.
   logic signed [FSKDB_DW+9:0] s1_q;
   logic signed [FSKDB_DW+9:0] s2_q;

   function automatic logic signed [FSKDB_DW+9:0] step(
      input logic signed [FSKDB_DW+9:0] s,
      input logic signed [FSKDB_DW+9:0] t,
      input logic [9:0] kk
   );
      logic signed [FSKDB_DW+10:0] diff;
      logic signed [FSKDB_DW+21:0] prod;
      diff = {t[FSKDB_DW+9], t} - {s[FSKDB_DW+9], s};
      prod = diff * $signed({1'b0, kk});
      step = s + prod[FSKDB_DW+19:10];
   endfunction

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (in_valid) begin
         s1_q <= step(s1_q, {x, 10'h000}, k);
         s2_q <= step(s2_q, s1_q, k);
      end
   end

   assign y = s2_q[FSKDB_DW+9:10];
endmodule
`default_nettype wire

// ==== rtl/fskdb_top.sv ====
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fskdb_top (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic demod_valid,
   input wire logic [fskdb_pkg::FSKDB_DW-1:0] corr_upper_level,
   input wire logic [fskdb_pkg::FSKDB_DW-1:0] corr_lower_level,
   input wire logic signed [fskdb_pkg::FSKDB_DW-1:0] linear_freq,
   output logic rx_data,
   output logic rx_bit_clock,
   output logic sync_match,
   output logic irq
);
   import fskdb_pkg::*;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic [4:0] popcount24(input logic [23:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < 24; i++) begin
         c = c + {4'h0, v[i]};
      end
      popcount24 = c;
   endfunction

   function automatic logic [23:0] len_mask(input logic [1:0] code);
      logic [23:0] m;
      unique case (code)
         2'h0: m = 24'h00_0FFF;
         2'h1: m = 24'h00_FFFF;
         2'h2: m = 24'h0F_FFFF;
         2'h3: m = 24'hFF_FFFF;
      endcase
      len_mask = m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [31:0] setup_q;
   logic [31:0] corr_q;
   logic [7:0] sync_cfg_q;
   logic [23:0] sync_word_q;
   logic [15:0] cdr_div_q;
   logic [0:0] status_q;
   logic [0:0] mask_q;
   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   logic bus_req;
   logic bus_wr;
   logic bus_rd;
   logic match_event;
   logic [4:0] phase_q;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
   assign bus_wr = bus_req && wb_we_i;
   assign bus_rd = bus_req && !wb_we_i;

   logic [1:0] demod_sel;
   logic [9:0] pf_bw;
   logic [2:0] demod_mode;
   logic [1:0] sync_len;
   logic [1:0] sync_tol;

   assign demod_sel = setup_q[FSKDB_SEL_LSB +: 2];
   assign pf_bw = setup_q[FSKDB_BW_LSB +: 10];
   assign demod_mode = setup_q[FSKDB_MODE_LSB +: 3];
   assign sync_len = sync_cfg_q[FSKDB_LEN_LSB +: 2];
   assign sync_tol = sync_cfg_q[FSKDB_TOL_LSB +: 2];

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         setup_q <= FSKDB_RST_SETUP;
         corr_q <= FSKDB_RST_CORR;
         sync_cfg_q <= FSKDB_RST_SYNC_CFG;
         sync_word_q <= FSKDB_RST_SYNC_WORD;
         cdr_div_q <= FSKDB_RST_CDR_DIV;
         mask_q <= 1'b0;
      end else if (bus_wr) begin
         unique case (wb_adr_i)
            FSKDB_ADR_SETUP: setup_q <= merge(setup_q, wb_dat_i, wb_sel_i);
            FSKDB_ADR_CORR: corr_q <= merge(corr_q, wb_dat_i, wb_sel_i);
            FSKDB_ADR_SYNC_CFG: begin
               if (wb_sel_i[0]) begin
                  sync_cfg_q <= wb_dat_i[7:0];
               end
            end
            FSKDB_ADR_SYNC_WORD: begin
               sync_word_q <= 24'(merge({8'h00, sync_word_q}, wb_dat_i, wb_sel_i));
            end
            FSKDB_ADR_MASK: begin
               if (wb_sel_i[0]) begin
                  mask_q <= wb_dat_i[0];
               end
            end
            FSKDB_ADR_CDR_DIV: begin
               cdr_div_q <= 16'(merge({16'h0000, cdr_div_q}, wb_dat_i, wb_sel_i));
            end
            default: begin
            end
         endcase
      end
   end

   // A read of the status register clears it; a match in the same cycle survives.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= 1'b0;
      end else if (match_event) begin
         status_q <= 1'b1;
      end else if (bus_rd && wb_adr_i == FSKDB_ADR_STATUS) begin
         status_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (status_q[0] || match_event) && mask_q[0];
      end
   end

   // Every access is answered one cycle after it is seen; unmapped reads give zero.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0000_0000;
      end else begin
         wb_ack_q <= bus_req;
         if (bus_rd) begin
            unique case (wb_adr_i)
               FSKDB_ADR_SETUP: wb_dat_q <= setup_q;
               FSKDB_ADR_CORR: wb_dat_q <= corr_q;
               FSKDB_ADR_SYNC_CFG: wb_dat_q <= {24'h00_0000, sync_cfg_q};
               FSKDB_ADR_SYNC_WORD: wb_dat_q <= {8'h00, sync_word_q};
               FSKDB_ADR_STATUS: wb_dat_q <= {31'h0000_0000, status_q};
               FSKDB_ADR_MASK: wb_dat_q <= {31'h0000_0000, mask_q};
               FSKDB_ADR_LIVE: wb_dat_q <= {24'h00_0000, phase_q, sync_match, rx_bit_clock, rx_data};
               FSKDB_ADR_CDR_DIV: wb_dat_q <= {16'h0000, cdr_div_q};
               default: wb_dat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;

   // ---------------------------------------------------------------
   // Demodulator front: correlator and linear discriminators
   // ---------------------------------------------------------------
   logic signed [FSKDB_DW-1:0] disc_d;
   logic signed [FSKDB_DW-1:0] filt_y;
   logic signed [FSKDB_DW:0] corr_diff;

   // The correlator output is the upper level minus the lower one.
   assign corr_diff = $signed({1'b0, corr_upper_level}) - $signed({1'b0, corr_lower_level});

   always_comb begin
      if (demod_sel == FSKDB_SEL_CORR) begin
         disc_d = corr_diff[FSKDB_DW:1];
      end else begin
         disc_d = linear_freq;
      end
   end

   // Both paths share one post filter and its setting.
   fskdb_lpf2 u_postfilter (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(demod_valid),
      .x(disc_d),
      .k(pf_bw),
      .y(filt_y)
   );

   // ---------------------------------------------------------------
   // Linear path averaging and envelope
   // ---------------------------------------------------------------
   // The averaging is slow so that long runs only drift the threshold a little.
   logic signed [FSKDB_DW+FSKDB_AVG_SHIFT-1:0] avg_q;
   logic signed [FSKDB_DW-1:0] env_hi_q;
   logic signed [FSKDB_DW-1:0] env_lo_q;
   logic signed [FSKDB_DW-1:0] avg_y;
   logic signed [FSKDB_DW:0] env_mid;

   assign avg_y = avg_q[FSKDB_DW+FSKDB_AVG_SHIFT-1:FSKDB_AVG_SHIFT];
   assign env_mid = ($signed({env_hi_q[FSKDB_DW-1], env_hi_q}) +
                     $signed({env_lo_q[FSKDB_DW-1], env_lo_q})) >>> 1;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         avg_q <= '0;
         env_hi_q <= '0;
         env_lo_q <= '0;
      end else if (demod_valid) begin
         avg_q <= avg_q + {{FSKDB_AVG_SHIFT{filt_y[FSKDB_DW-1]}}, filt_y}
                  - {{FSKDB_AVG_SHIFT{avg_y[FSKDB_DW-1]}}, avg_y};
         if (filt_y > env_hi_q) begin
            env_hi_q <= filt_y;
         end else if (env_hi_q > avg_y) begin
            env_hi_q <= env_hi_q - 12'sh001;
         end
         if (filt_y < env_lo_q) begin
            env_lo_q <= filt_y;
         end else if (env_lo_q < avg_y) begin
            env_lo_q <= env_lo_q + 12'sh001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bit slicer
   // ---------------------------------------------------------------
   logic slice_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         slice_q <= 1'b0;
      end else if (demod_valid) begin
         if (demod_sel == FSKDB_SEL_CORR) begin
            slice_q <= !filt_y[FSKDB_DW-1];
         end else begin
            slice_q <= $signed({filt_y[FSKDB_DW-1], filt_y}) > env_mid;
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock recovery PLL
   // ---------------------------------------------------------------
   logic [15:0] div_cnt_q;
   logic os_tick;
   logic slice_prev_q;
   logic bit_strobe;

   // Lowering the divider must not strand the counter above it for a full wrap.
   assign os_tick = (div_cnt_q >= cdr_div_q);
   assign bit_strobe = os_tick && (phase_q == FSKDB_PHASE_SAMPLE);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_q <= 16'h0000;
      end else if (os_tick) begin
         div_cnt_q <= 16'h0000;
      end else begin
         div_cnt_q <= div_cnt_q + 16'h0001;
      end
   end

   // Each edge nudges the phase by one of 32 steps toward the bit boundary,
   // a pull range of about three percent for alternating data.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= 5'h00;
         slice_prev_q <= 1'b0;
      end else if (os_tick) begin
         slice_prev_q <= slice_q;
         if (slice_q != slice_prev_q && phase_q != 5'h00) begin
            if (phase_q < FSKDB_PHASE_SAMPLE) begin
               phase_q <= phase_q;
            end else begin
               phase_q <= phase_q + 5'h02;
            end
         end else begin
            phase_q <= phase_q + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_data <= 1'b0;
         rx_bit_clock <= 1'b0;
      end else begin
         if (bit_strobe) begin
            rx_data <= slice_q;
         end
         rx_bit_clock <= phase_q >= FSKDB_PHASE_SAMPLE;
      end
   end

   // ---------------------------------------------------------------
   // Sync word detector
   // ---------------------------------------------------------------
   logic [23:0] hist_q;
   logic [23:0] hist_d;
   logic [4:0] errs;
   logic sync_on;
   logic [3:0] hold_q;

   // Newest bit enters at the bottom, so a word sent first-bit-first lines up.
   assign hist_d = {hist_q[22:0], slice_q};
   assign errs = popcount24((hist_d ^ sync_word_q) & len_mask(sync_len));
   assign sync_on = (demod_mode == FSKDB_MODE_SYNC_A) || (demod_mode == FSKDB_MODE_SYNC_B);
   assign match_event = bit_strobe && sync_on && (errs <= {3'h0, sync_tol});

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hist_q <= 24'h00_0000;
      end else if (bit_strobe) begin
         hist_q <= hist_d;
      end
   end

   // The pin stays up nine recovered bits; a fresh match restarts the count.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hold_q <= 4'h0;
         sync_match <= 1'b0;
      end else if (match_event) begin
         hold_q <= FSKDB_MATCH_HOLD_BITS;
         sync_match <= 1'b1;
      end else if (bit_strobe && hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
         sync_match <= hold_q != 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== dv/fskdb_tx_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Far-end sample source: one bit per 32 clocks, alternating bits when idle.
// ---------------------------------------------------------------
module fskdb_tx_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [47:0] frame,
   output logic busy,
   output logic demod_valid,
   output logic [fskdb_pkg::FSKDB_DW-1:0] corr_upper_level,
   output logic [fskdb_pkg::FSKDB_DW-1:0] corr_lower_level,
   output logic signed [fskdb_pkg::FSKDB_DW-1:0] linear_freq
);
   import fskdb_pkg::*;
   logic [47:0] shift_q;
   logic [5:0] left_q;
   logic [4:0] tick_q;
   logic idle_q;
   logic bit_w;
   // Idle traffic keeps toggling so a stale level never looks like data.
   assign bit_w = busy ? shift_q[47] : idle_q;
   assign busy = left_q != 6'h00;
   assign corr_upper_level = bit_w ? 12'h600 : 12'h080;
   assign corr_lower_level = bit_w ? 12'h080 : 12'h600;
   assign linear_freq = bit_w ? 12'sh200 : 12'shE00;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= 48'h0;
         left_q <= 6'h00;
         tick_q <= 5'h00;
         idle_q <= 1'b0;
         demod_valid <= 1'b0;
      end else begin
         demod_valid <= 1'b1;
         tick_q <= tick_q + 5'h01;
         if (start) begin
            shift_q <= frame;
            left_q <= 6'h30;
            tick_q <= 5'h00;
         end else if (tick_q == 5'h1F) begin
            idle_q <= ~idle_q;
            if (busy) begin
               shift_q <= shift_q << 1;
               left_q <= left_q - 6'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/fskdb_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module fskdb_chk (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rx_data,
   input wire logic rx_bit_clock,
   input wire logic sync_match,
   input wire logic irq
);
   import fskdb_pkg::*;
   logic bitclk_q;
   logic [3:0] strb_cnt_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) bitclk_q <= 1'b0;
      else bitclk_q <= rx_bit_clock;
   end
   // Counts bit strobes seen while the match pin is up; saturates to stay bounded.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) strb_cnt_q <= 4'h0;
      else if (!sync_match) strb_cnt_q <= 4'h0;
      else if (rx_bit_clock && !bitclk_q && strb_cnt_q != 4'hF) strb_cnt_q <= strb_cnt_q + 4'h1;
   end
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence match_rise_s;
      !sync_match ##1 sync_match;
   endsequence
   ack_reply_a: assert property (req_s |=> wb_ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   data_at_strobe_a: assert property ($changed(rx_data) |-> $rose(rx_bit_clock))
      else $error("data changed off the bit strobe");
   match_at_strobe_a: assert property (match_rise_s |-> rx_bit_clock && !$past(rx_bit_clock))
      else $error("match raised off the bit strobe");
   match_len_a: assert property ($fell(sync_match) |-> strb_cnt_q inside {4'h8, 4'h9})
      else $error("match pin length wrong");
   match_cap_a: assert property (strb_cnt_q <= 4'h9)
      else $error("match pin held too long");
   irq_clear_a: assert property ($fell(irq) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
      else $error("irq dropped without access");
endmodule
`default_nettype wire

// ==== dv/fskdb_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module fskdb_top_tb;
   import fskdb_pkg::*;
   // Data rate is one bit per 32 clocks with the divider at its reset value.
   localparam int BW = int'(1024.0 * 2.0 * 3.14159265 * 0.75 * 625.0e3 / 20.0e6);
   localparam int CBW = int'(20.0e6 / (4.0 * 300.0e3));
   localparam logic [23:0] SYNC_W = 24'hC35E91;
   logic clk_sys, arst_n, cyc, stb, we, start, seen, busy, dv, rx_data, bclk, sync_match, irq, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dat_o;
   logic [47:0] frame;
   logic bclk_d;
   logic [23:0] rx_sh, rx_word;
   logic [11:0] up, lo;
   logic signed [11:0] lin;
   int hi_n, err_count, checks;
   fskdb_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .demod_valid(dv), .corr_upper_level(up), .corr_lower_level(lo),
      .linear_freq(lin), .rx_data(rx_data), .rx_bit_clock(bclk), .sync_match(sync_match),
      .irq(irq));
   fskdb_tx_model u_tx (.clk_sys(clk_sys), .arst_n(arst_n), .start(start), .frame(frame),
      .busy(busy), .demod_valid(dv), .corr_upper_level(up), .corr_lower_level(lo),
      .linear_freq(lin));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Recovered bits are taken on each rise of the bit clock; the word at the match is kept.
   always @(posedge clk_sys) begin
      bclk_d <= bclk;
      if (bclk === 1'b1 && bclk_d === 1'b0) begin
         rx_sh <= {rx_sh[22:0], rx_data};
         if (sync_match === 1'b1 && seen !== 1'b1) begin
            rx_word <= {rx_sh[22:0], rx_data};
         end
      end
      if (sync_match === 1'b1) begin
         seen <= 1'b1;
         hi_n <= hi_n + 1;
      end
   end
   task automatic stop_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Entered just after a rising edge; leaves one idle cycle before returning.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 16);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys);
      if (n >= 16) begin
         err_count++;
         stop_test();
      end
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      chk(nm, e, rdat);
   endtask
   task automatic run(input logic [1:0] s, input logic [2:0] m, input logic [1:0] l,
         input logic [1:0] t, input logic k, input logic [23:0] f, input logic e);
      wb(FSKDB_ADR_SETUP, 1'b1, (32'(m) << FSKDB_MODE_LSB) | (32'(BW) << FSKDB_BW_LSB)
         | (32'(s) << FSKDB_SEL_LSB));
      wb(FSKDB_ADR_SYNC_CFG, 1'b1, 32'({t, l}) << FSKDB_LEN_LSB);
      wb(FSKDB_ADR_MASK, 1'b1, {31'h0, k});
      seen <= 1'b0;
      rx_word <= 24'h00_0000;
      hi_n <= 0;
      frame <= {24'hAAAAAA, SYNC_W ^ f};
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      // Frame of 48 bits, then twelve more so a nine-bit match pulse has ended.
      repeat (60 * 32) @(posedge clk_sys);
      chk("match", {31'h0, e}, {31'h0, seen});
      if (e) chk("match_len", 32'h1, {31'h0, hi_n >= 287 && hi_n <= 289});
      if (e) chk("rx_word", {8'h00, SYNC_W ^ f}, {8'h00, rx_word});
      chk("irq", {31'h0, e & k}, {31'h0, irq});
      rd("status", FSKDB_ADR_STATUS, {31'h0, e});
      repeat (3) @(posedge clk_sys);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      rd("status_cleared", FSKDB_ADR_STATUS, 32'h0);
   endtask
   initial begin
      arst_n = 1'b0;
      {cyc, stb, we, start, seen} = 5'h00;
      adr = 8'h00;
      sel = 4'hF;
      wdat = 32'h0;
      frame = 48'h0;
      hi_n = 0;
      err_count = 0;
      checks = 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      rd("setup", FSKDB_ADR_SETUP, FSKDB_RST_SETUP);
      rd("corr", FSKDB_ADR_CORR, FSKDB_RST_CORR);
      rd("sync_cfg", FSKDB_ADR_SYNC_CFG, 32'(FSKDB_RST_SYNC_CFG));
      rd("sync_word", FSKDB_ADR_SYNC_WORD, 32'(FSKDB_RST_SYNC_WORD));
      rd("cdr_div", FSKDB_ADR_CDR_DIV, 32'(FSKDB_RST_CDR_DIV));
      rd("unmapped", 8'h20, 32'h0);
      wb(FSKDB_ADR_CORR, 1'b1, 32'(CBW) << FSKDB_CBW_LSB);
      rd("corr_bw", FSKDB_ADR_CORR, 32'(CBW) << FSKDB_CBW_LSB);
      wb(FSKDB_ADR_CDR_DIV, 1'b1, 32'h0000_00A5);
      rd("cdr_div_rw", FSKDB_ADR_CDR_DIV, 32'h0000_00A5);
      wb(FSKDB_ADR_CDR_DIV, 1'b1, 32'(FSKDB_RST_CDR_DIV));
      wb(FSKDB_ADR_SYNC_WORD, 1'b1, 32'(SYNC_W));
      run(FSKDB_SEL_CORR, 3'h2, 2'h3, 2'h0, 1'b1, 24'h0, 1'b1);
      run(FSKDB_SEL_CORR, 3'h3, 2'h3, 2'h1, 1'b1, 24'h000081, 1'b0);
      run(FSKDB_SEL_CORR, 3'h3, 2'h3, 2'h2, 1'b0, 24'h000081, 1'b1);
      run(FSKDB_SEL_CORR, 3'h1, 2'h3, 2'h0, 1'b1, 24'h0, 1'b0);
      run(FSKDB_SEL_LINEAR, 3'h2, 2'h0, 2'h0, 1'b1, 24'h100000, 1'b1);
      run(FSKDB_SEL_CORR, 3'h2, 2'h1, 2'h0, 1'b1, 24'h004000, 1'b0);
      stop_test();
   end
endmodule
bind fskdb_top fskdb_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .rx_data(rx_data), .rx_bit_clock(rx_bit_clock),
   .sync_match(sync_match), .irq(irq));
`default_nettype wire
